/* File: verilog/hbcfg_regs.sv */
// Half-bridge PWM and gate-drive configuration register bank
`timescale 1ns/10ps
`include "hbcfg_consts.svh"

// Contract
// RULE1: Mode bit 0 full on, 1 PWM
// RULE2: Source code 00..11 picks PWM input 1..4
// RULE3: Bit 10 splits source register into A/B
// RULE4: Cal delay 0.35..3.35 us, 0.2 us steps
// RULE5: Cal pre-charge 50..1550 ns, 100 ns steps
// RULE6: Cal select 000/111 off, else channel
// RULE7: Blanking code selects 1..4 us
// RULE8: Fall pre-charge current code, eight levels
// RULE9: Rise pre-charge current code, eight levels
// RULE10: Pre-charge time code selects 100..400 ns
// RULE11: Host changes drive only while tri-stated
// RULE12: Write touches only addressed register bits
module hbcfg_regs
  import hbcfg_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         frame_valid_i,
  input  wire logic [15:0]                  frame_word_i,
  input  wire logic [3:0]                   pwm_in_i,
  output logic      [`HBCFG_NCH-1:0]        pwm_mode_o,
  output logic      [2*`HBCFG_NCH-1:0]      pwm_src_sel_o,
  output logic      [`HBCFG_NCH-1:0]        chan_drive_o,
  output logic      [3:0]                   cal_end_delay_o,
  output logic      [3:0]                   cal_start_pc_o,
  output logic      [2:0]                   cal_chan_sel_o,
  output logic                              cal_enable_o,
  output logic      [`HBCFG_NCH-1:0]        cal_chan_onehot_o,
  output hbcfg_gd_t [`HBCFG_NCH-1:0]        gd_cfg_o
);

  // ****************************************
  // Frame decode
  // ****************************************
  hbcfg_frame_t                 frame;
  logic [3:0]                   addr;
  logic                         sub_b;
  logic [`HBCFG_DATA_W-1:0]     data;
  logic                         wr_mode;
  logic                         wr_src_a;
  logic                         wr_src_b;
  logic                         wr_cal;
  logic [3:0]                   pwm_in_s1_q;
  logic [3:0]                   pwm_in_s2_q;

  assign frame    = '{valid: frame_valid_i, word: frame_word_i};
  assign addr     = frame.word[`HBCFG_ADDR_MSB:`HBCFG_ADDR_LSB];
  assign sub_b    = frame.word[`HBCFG_SUB_BIT];
  assign data     = frame.word[`HBCFG_DATA_W-1:0];
  assign wr_mode  = frame.valid && addr == `HBCFG_ADDR_MODE;       // RULE12
  assign wr_src_a = frame.valid && addr == `HBCFG_ADDR_SRC
                    && !sub_b;                                      // RULE3
  assign wr_src_b = frame.valid && addr == `HBCFG_ADDR_SRC
                    && sub_b;                                       // RULE3
  assign wr_cal   = frame.valid && addr == `HBCFG_ADDR_CAL;        // RULE12

  // Channel a gate-drive address belongs to, or NCH when none
  function automatic logic [2:0] gd_chan(input logic [3:0] a);
    if (a >= `HBCFG_ADDR_GD_LO && a <= `HBCFG_ADDR_GD_HI) begin
      gd_chan = 3'(a - `HBCFG_ADDR_GD_LO);
    end else begin
      gd_chan = 3'(`HBCFG_NCH);
    end
  endfunction

  // ****************************************
  // Mode, source and calibration storage
  // ****************************************
  logic [`HBCFG_NCH-1:0]   mode_q;
  logic [2*`HBCFG_NCH-1:0] src_q;
  hbcfg_cal_t              cal_q;
  hbcfg_cal_t              cal_d;

  assign cal_d = '{end_delay: data[`HBCFG_CAL_DLY_LSB+:4],  // RULE4
                   start_pc:  data[`HBCFG_CAL_PC_LSB+:4],   // RULE5
                   chan_sel:  data[`HBCFG_CAL_SEL_LSB+:3]};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= 6'(`HBCFG_RESET_VAL);
    end else if (wr_mode) begin
      mode_q <= data[`HBCFG_NCH-1:0];                        // RULE1
    end
  end

  // Only bits 9:0 in sub-register A, bits 1:0 in B
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_q <= 12'h000;
    end else if (wr_src_a) begin
      src_q[9:0] <= data[9:0];                               // RULE3
    end else if (wr_src_b) begin
      src_q[11:10] <= data[1:0];                             // RULE3
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cal_q <= hbcfg_cal_t'(`HBCFG_RESET_VAL);
    end else if (wr_cal) begin
      cal_q <= cal_d;                                        // RULE12
    end
  end

  // ****************************************
  // Per-channel gate-drive registers
  // ****************************************
  // Host must only rewrite these while the channel is tri-stated;
  // no lockout here, the enable lives in another bank.  RULE11
  hbcfg_gd_t [`HBCFG_NCH-1:0] gd_cfg;
  logic      [2:0]            gd_sel;

  assign gd_sel = gd_chan(addr);

  // ****************************************
  // PWM routing, input sync and outputs
  // ****************************************
  logic [`HBCFG_NCH-1:0] drive_d;
  logic [`HBCFG_NCH-1:0] cal_hot_d;
  logic                  cal_en_d;

  assign cal_en_d = cal_q.chan_sel != `HBCFG_CAL_OFF_LO
                    && cal_q.chan_sel != `HBCFG_CAL_OFF_HI;  // RULE6

  genvar g;
  generate
    for (g = 0; g < `HBCFG_NCH; g++) begin : g_ch
      hbcfg_gd_reg u_gd (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .wr_i     (frame.valid && !sub_b && gd_sel == 3'(g)),
        .data_i   (data),
        .cfg_o    (gd_cfg[g])
      );
      // Mode 0 holds the output fully on
      assign drive_d[g] = !mode_q[g]
                          || pwm_in_s2_q[src_q[2*g+:2]];     // RULE1 RULE2
      assign cal_hot_d[g] = cal_en_d
                            && cal_q.chan_sel == 3'(g + 1);  // RULE6
    end
  endgenerate

  // PWM pins are asynchronous to the logic clock
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_in_s1_q <= 4'h0;
      pwm_in_s2_q <= 4'h0;
    end else begin
      pwm_in_s1_q <= pwm_in_i;
      pwm_in_s2_q <= pwm_in_s1_q;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chan_drive_o      <= 6'h00;
      cal_enable_o      <= 1'b0;
      cal_chan_onehot_o <= 6'h00;
    end else begin
      chan_drive_o      <= drive_d;
      cal_enable_o      <= cal_en_d;
      cal_chan_onehot_o <= cal_hot_d;
    end
  end

  // Stored registers are already flops
  assign pwm_mode_o      = mode_q;
  assign pwm_src_sel_o   = src_q;
  assign cal_end_delay_o = cal_q.end_delay;
  assign cal_start_pc_o  = cal_q.start_pc;
  assign cal_chan_sel_o  = cal_q.chan_sel;
  assign gd_cfg_o        = gd_cfg;

endmodule // hbcfg_regs

/* File: verilog/hbcfg_consts.svh */
// Frame layout, register addresses and field positions of the config bank
`ifndef HBCFG_CONSTS_SVH
`define HBCFG_CONSTS_SVH

// Frame: 4 address bits, watchdog bit, 11 data bits
`define HBCFG_ADDR_MSB     15
`define HBCFG_ADDR_LSB     12
`define HBCFG_SUB_BIT      10
`define HBCFG_DATA_W       11
`define HBCFG_NCH          6

// Register addresses
`define HBCFG_ADDR_MODE    4'h2
`define HBCFG_ADDR_SRC     4'h3
`define HBCFG_ADDR_CAL     4'h4
`define HBCFG_ADDR_GD_LO   4'h5
`define HBCFG_ADDR_GD_HI   4'ha

// Field positions inside the 11 data bits
`define HBCFG_CAL_DLY_LSB  7
`define HBCFG_CAL_PC_LSB   3
`define HBCFG_CAL_SEL_LSB  0
`define HBCFG_BLANK_LSB    8
`define HBCFG_IPCF_LSB     5
`define HBCFG_IPCR_LSB     2
`define HBCFG_TPC_LSB      0

// Calibration channel codes that park the unit
`define HBCFG_CAL_OFF_LO   3'h0
`define HBCFG_CAL_OFF_HI   3'h7

// Reset value of every stored field
`define HBCFG_RESET_VAL    11'h000

`endif

/* File: verilog/hbcfg_pkg.sv */
// Types shared by the gate-drive config bank
package hbcfg_pkg;

  typedef struct packed {
    logic [1:0] blank;
    logic [2:0] fall_ipc;
    logic [2:0] rise_ipc;
    logic [1:0] pc_time;
  } hbcfg_gd_t;

  typedef struct packed {
    logic [3:0] end_delay;
    logic [3:0] start_pc;
    logic [2:0] chan_sel;
  } hbcfg_cal_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } hbcfg_frame_t;

endpackage

/* File: verilog/hbcfg_gd_reg.sv */
// One channel's gate-drive configuration A register
`timescale 1ns/10ps
`include "hbcfg_consts.svh"

module hbcfg_gd_reg
  import hbcfg_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  input  wire logic                     wr_i,
  input  wire logic [`HBCFG_DATA_W-1:0] data_i,
  output hbcfg_gd_t                     cfg_o
);

  hbcfg_gd_t cfg_q;
  hbcfg_gd_t cfg_d;

  // Bit 10 is fixed zero in this layout and dropped
  assign cfg_d = '{blank:    data_i[`HBCFG_BLANK_LSB+:2],   // RULE7
                   fall_ipc: data_i[`HBCFG_IPCF_LSB+:3],    // RULE8
                   rise_ipc: data_i[`HBCFG_IPCR_LSB+:3],    // RULE9
                   pc_time:  data_i[`HBCFG_TPC_LSB+:2]};    // RULE10

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q <= hbcfg_gd_t'(10'(`HBCFG_RESET_VAL));
    end else if (wr_i) begin
      cfg_q <= cfg_d;                                       // RULE12
    end
  end

  assign cfg_o = cfg_q;

endmodule // hbcfg_gd_reg

/* File: bench/hbcfg_host.sv */
// Host model issuing write frames to the config bank
`timescale 1ns/10ps
module hbcfg_host (
  input  wire logic   clk_i,
  output logic        frame_valid_o,
  output logic [15:0] frame_word_o
);
  initial begin
    frame_valid_o = 1'b0;
    frame_word_o  = 16'h0;
  end
  // Drive one frame with valid high for one clock cycle, whatever the output state
  task automatic send(input logic [15:0] w);
    @(posedge clk_i) #1;
    frame_valid_o = 1'b1;
    frame_word_o  = w;
    @(posedge clk_i) #1;
    frame_valid_o = 1'b0;
    // Stale word inverted so it never passes for a fresh one
    frame_word_o  = ~w;
  endtask
endmodule // hbcfg_host

/* File: bench/hbcfg_regs_assertions.sv */
// Port checker for the config bank
`timescale 1ns/10ps
module hbcfg_regs_chk
  import hbcfg_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            resetn_i,
  input wire logic            frame_valid_i,
  input wire logic [15:0]     frame_word_i,
  input wire logic [5:0]      pwm_mode_o,
  input wire logic [11:0]     pwm_src_sel_o,
  input wire logic [5:0]      chan_drive_o,
  input wire logic [3:0]      cal_end_delay_o,
  input wire logic [3:0]      cal_start_pc_o,
  input wire logic [2:0]      cal_chan_sel_o,
  input wire logic            cal_enable_o,
  input wire logic [5:0]      cal_chan_onehot_o,
  input wire hbcfg_gd_t [5:0] gd_cfg_o
);
  wire [3:0] adr = frame_word_i[15:12];
  wire       wr  = frame_valid_i;
  wire       sub = frame_word_i[10];
  wire hit = adr inside {[4'h2:4'h4]} || (adr inside {[4'h5:4'ha]} && !sub);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ***********
  // Properties
  // ***********
  chk_mode_store: assert property (wr && adr == 4'h2 |=>
    pwm_mode_o == $past(frame_word_i[5:0])) else $error("mode lost");
  chk_src_a: assert property (wr && adr == 4'h3 && !sub |=>
    pwm_src_sel_o[9:0] == $past(frame_word_i[9:0])) else $error("src a");
  chk_src_b: assert property (wr && adr == 4'h3 && sub |=>
    pwm_src_sel_o[11:10] == $past(frame_word_i[1:0])
    && $stable(pwm_src_sel_o[9:0])) else $error("src b");
  chk_cal_store: assert property (wr && adr == 4'h4 |=>
    {cal_end_delay_o, cal_start_pc_o, cal_chan_sel_o}
    == $past(frame_word_i[10:0])) else $error("cal lost");
  for (genvar c = 0; c < 6; c++) begin : g_gd
    chk_gd_store: assert property (
      wr && !sub && adr == 4'(c + 5)
      |=> gd_cfg_o[c] == $past(frame_word_i[9:0])) else $error("gd lost");
  end
  chk_ignore_miss: assert property (wr && !hit |=>
    $stable({pwm_mode_o, pwm_src_sel_o, cal_end_delay_o, cal_start_pc_o,
    cal_chan_sel_o, gd_cfg_o})) else $error("miss wrote");
  chk_full_on: assert property ($past(resetn_i) |=>
    (chan_drive_o | $past(pwm_mode_o)) == 6'h3f) else $error("not on");
  chk_cal_enable: assert property (
    cal_enable_o == ($past(cal_chan_sel_o) inside {[3'h1:3'h6]}))
    else $error("cal enable");
  chk_cal_onehot: assert property (cal_chan_onehot_o ==
    (cal_enable_o ? 6'(6'h1 << ($past(cal_chan_sel_o) - 3'h1)) : 6'h0))
    else $error("cal onehot");
  cover property (wr && adr == 4'h3 && sub);
  cover property (cal_enable_o);
  cover property (wr && !hit);
endmodule // hbcfg_regs_chk
bind hbcfg_regs hbcfg_regs_chk hbcfg_regs_chk_i (.*);

/* File: bench/test_halfbridge_pwm_gate_config_regs.sv */
// Self-checking bench for the config bank
`timescale 1ns/10ps
module test_halfbridge_pwm_gate_config_regs
  import hbcfg_pkg::*;
;
  logic            clk_i = 1'b0;
  logic            resetn_i;
  logic            frame_valid_i;
  logic [15:0]     frame_word_i;
  logic [3:0]      pwm_in_i;
  logic [5:0]      pwm_mode_o, chan_drive_o, cal_chan_onehot_o;
  logic [11:0]     pwm_src_sel_o;
  logic [3:0]      cal_end_delay_o, cal_start_pc_o;
  logic [2:0]      cal_chan_sel_o;
  logic            cal_enable_o;
  hbcfg_gd_t [5:0] gd_cfg_o;
  int              errors = 0;
  int              checks_done = 0;
  wire [101:0] all_o = {pwm_mode_o, pwm_src_sel_o, chan_drive_o,
    cal_end_delay_o, cal_start_pc_o, cal_chan_sel_o, cal_enable_o,
    cal_chan_onehot_o, gd_cfg_o};
  always #25 clk_i = ~clk_i;
  hbcfg_host hbcfg_host_i (.clk_i, .frame_valid_o(frame_valid_i),
    .frame_word_o(frame_word_i));
  hbcfg_regs hbcfg_regs_i (
    .clk_i             (clk_i),
    .resetn_i          (resetn_i),
    .frame_valid_i     (frame_valid_i),
    .frame_word_i      (frame_word_i),
    .pwm_in_i          (pwm_in_i),
    .pwm_mode_o        (pwm_mode_o),
    .pwm_src_sel_o     (pwm_src_sel_o),
    .chan_drive_o      (chan_drive_o),
    .cal_end_delay_o   (cal_end_delay_o),
    .cal_start_pc_o    (cal_start_pc_o),
    .cal_chan_sel_o    (cal_chan_sel_o),
    .cal_enable_o      (cal_enable_o),
    .cal_chan_onehot_o (cal_chan_onehot_o),
    .gd_cfg_o          (gd_cfg_o)
  );
  // ***********
  // Tasks
  // ***********
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_mode;
    hbcfg_host_i.send(16'h27d5);
    cmp(pwm_mode_o, 6'h15);
    cyc(1);
    cmp(chan_drive_o, 6'h2a);
    $display("mode test done");
  endtask
  task automatic t_src;
    pwm_in_i = 4'ha;
    hbcfg_host_i.send(16'h2c3f);
    hbcfg_host_i.send(16'h30e4);
    hbcfg_host_i.send(16'h3403);
    cmp(pwm_src_sel_o, 12'hce4);
    cyc(3);
    cmp(chan_drive_o, 6'h2a);
    pwm_in_i = 4'h5;
    cyc(3);
    cmp(chan_drive_o, 6'h15);
    $display("source test done");
  endtask
  task automatic t_cal;
    logic [15:0] w;
    logic [5:0]  oh;
    logic [10:0] cal;
    for (int s = 0; s < 8; s++) begin
      w = {5'h08, s[0] ? 4'hf : 4'h0, 4'(s), 3'(s)};
      hbcfg_host_i.send(w);
      cal = {cal_end_delay_o, cal_start_pc_o, cal_chan_sel_o};
      cmp(cal, w[10:0]);
      cyc(1);
      oh = (s >= 1 && s <= 6) ? 6'h1 << (s - 1) : 6'h0;
      cmp({cal_enable_o, cal_chan_onehot_o}, {oh != 6'h0, oh});
    end
    $display("calibration test done");
  endtask
  task automatic t_gd;
    logic [9:0] d;
    for (int c = 0; c < 6; c++) begin
      d = {2'(c), 3'(7 - c), 3'(c), 2'h1};
      hbcfg_host_i.send({4'(c + 5), 2'b00, d});
      hbcfg_host_i.send({4'(c + 5), 2'b01, ~d});
      cmp(gd_cfg_o[c], d);
    end
    hbcfg_host_i.send(16'hbfff);
    hbcfg_host_i.send(16'hf7ff);
    cmp({pwm_mode_o, gd_cfg_o[5]}, {6'h3f, 10'h155});
    $display("gate drive test done");
  endtask
  // Mid-run reset must clear every stored code without a clock
  task automatic t_reset;
    resetn_i = 1'b0;
    #10;
    cmp(all_o, '0);
    cyc(2);
    resetn_i = 1'b1;
    cyc(1);
    cmp(chan_drive_o, 6'h3f);
    $display("reset test done");
  endtask
  initial begin
    resetn_i = 1'b0;
    pwm_in_i = 4'h0;
    repeat (8) @(posedge clk_i);
    #1;
    cmp(all_o, '0);
    resetn_i = 1'b1;
    t_mode();
    t_src();
    t_cal();
    t_gd();
    t_reset();
    test_done();
  end
  // Run needs under 200 cycles, so 100 us means a hang
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule // test_halfbridge_pwm_gate_config_regs
